// File: hw/dcw_defines.svh
// Named constants for the dynamic memory column-strobe controller
`ifndef DCW_DEFINES_SVH
`define DCW_DEFINES_SVH
`define DCW_ADDR_W      26
`define DCW_DATA_W      32
`define DCW_WAVE_W      96
`define DCW_WAVE_CNT_W  7
`define DCW_BEATS_MAX   4'h8
`define DCW_BEAT_W      4
`define DCW_TDL_W       2
`define DCW_TRP_W       4
`define DCW_ROWSEL_9    2'h0
`define DCW_ROWSEL_10   2'h1
`define DCW_ROWSEL_11   2'h2
`define DCW_ROWSEL_12   2'h3
`define DCW_MUX_LO      10
`define DCW_MUX_HI      21
`define DCW_RD_RELEASE  2'h2
`define DCW_CFG_RESET   1'h0
`endif

// File: hw/dcw_dram_ctrl.sv
// Dynamic memory access sequencer with shift-register column-strobe waveform
// What this block does
// - Drives one of four identical banks over a 32-bit data path.
// - Each access moves one to eight words, as the request says; a request of zero or above eight moves eight.
// - Row phase puts internal bits 18..10 on muxed pins 8..0, and bits 21..19 on pins 11..9 at every row width.
// - Column phase puts bits 9..2 on pins 7..0, upper pins per row width.
// - Muxed lines 11..0 are external address pins 21..10.
// - Row phase drives every address pin with the same-index internal bit.
// - Waveform advances every clock, or every second clock at half rate.
// - Shifting stops when strobe pulses equal the word count.
// - Three concatenated waveform words give the full burst, LSB first.
// - Row address first, one clock later row strobe falls and shifting starts.
// - Shifted-out one drives column strobe high, zero drives it low.
// - First column address is valid a cycle before the strobe first falls.
// - Reads latch data zero to three cycles after each strobe rising edge.
// - Writes release row strobe at next memory-clock edge after last strobe rise.
// - Reads release row strobe at memory-clock edge two or three after last latch.
// - Later column addresses change one clock after the strobe rises; write data reloads as it rises.
// - Write or output enable strobes follow row strobe timing.
// - After release, wait the precharge count before next row strobe.
// - The memory clock runs at half the controller clock.
`timescale 1ns/1ps
`include "dcw_defines.svh"
module dcw_dram_ctrl (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire dcw_pkg::dcw_cfg_s        cfg,
  input  wire logic [1:0]               bank_select,
  input  wire logic                     req_valid,
  input  wire dcw_pkg::dcw_req_s        req,
  input  wire logic [`DCW_DATA_W-1:0]   req_wdata,
  input  wire logic [`DCW_DATA_W-1:0]   mem_rdata,
  output logic                          req_ready,
  output logic                          rdata_valid,
  output logic [`DCW_DATA_W-1:0]        rdata,
  output logic                          done,
  output logic [`DCW_ADDR_W-1:0]        mem_addr,
  output logic [`DCW_DATA_W-1:0]        mem_wdata,
  output logic                          mem_data_oe_n,
  output logic [3:0]                    row_strobe_n,
  output logic                          column_strobe_n,
  output logic                          write_strobe_n,
  output logic                          output_enable_n,
  output logic                          mem_clk_phase
);

  // State registers
  dcw_pkg::dcw_state_e            state_reg, state_next;
  dcw_pkg::dcw_req_s              req_reg, req_next;
  logic [`DCW_DATA_W-1:0]         wdata_reg, wdata_next;
  logic [`DCW_WAVE_W-1:0]         wave_reg, wave_next;
  logic [`DCW_BEAT_W-1:0]         pulses_reg, pulses_next;
  logic [`DCW_BEAT_W-1:0]         latched_reg, latched_next;
  logic [`DCW_TDL_W:0]            lat_pipe_reg, lat_pipe_next;
  logic [3:0]                     lat_dly_reg, lat_dly_next;
  logic [`DCW_TRP_W-1:0]          wait_reg, wait_next;
  logic [1:0]                     hold_reg, hold_next;
  logic                           half_reg, half_next;
  logic                           mclk_reg, mclk_next;
  logic                           cas_reg, cas_next;
  logic                           ras_reg, ras_next;
  logic [1:0]                     bank_reg, bank_next;
  logic [`DCW_ADDR_W-1:0]         addr_reg, addr_next;
  logic [`DCW_DATA_W-1:0]         mwd_reg, mwd_next;
  logic                           oe_reg, oe_next;
  logic                           rv_reg, rv_next;
  logic [`DCW_DATA_W-1:0]         rd_reg, rd_next;
  logic                           done_reg, done_next;
  logic [`DCW_BEAT_W-1:0]         beat_reg, beat_next;
  logic [11:0]                    row_mux, col_mux;
  logic                           shift_en, cas_rise, last_pulse, latch_now;

  // Row-phase muxed lines: same-index internal bits on all twelve lines at every width
  always_comb begin
    row_mux       = 12'h000;
    row_mux[8:0]  = req_reg.addr[18:10];
    // Unused upper lines are don't-care to the part, so same-index bits suit all widths
    row_mux[9]    = req_reg.addr[19];
    row_mux[10]   = req_reg.addr[20];
    row_mux[11]   = req_reg.addr[21];
  end

  // Column-phase muxing picked from row width alone; beat index added to bits 4..2
  always_comb begin
    col_mux      = 12'h000;
    col_mux[7:0] = {req_reg.addr[9:5], req_reg.addr[4:2] + beat_reg[2:0]};
    case (cfg.row_bits_select)
      `DCW_ROWSEL_9: begin
        col_mux[8] = req_reg.addr[19];
      end
      `DCW_ROWSEL_10: begin
        col_mux[8] = req_reg.addr[20];
        col_mux[9] = req_reg.addr[21];
      end
      `DCW_ROWSEL_11: begin
        col_mux[8]  = req_reg.addr[21];
        col_mux[9]  = req_reg.addr[22];
        col_mux[10] = req_reg.addr[23];
      end
      default: begin
        col_mux[8] = req_reg.addr[22];
        col_mux[9] = req_reg.addr[23];
      end
    endcase
  end

  // Shift enable every clock or every other clock
  assign shift_en   = (state_reg == dcw_pkg::ST_SHIFT) &&
                      (!cfg.column_shift_half_rate || half_reg);
  // Rising edge of the strobe waveform as the next bit comes out
  assign cas_rise   = shift_en && !cas_reg && wave_reg[0];
  assign last_pulse = cas_rise && (pulses_reg + 4'h1 == req_reg.beats);
  // Programmable latch delay, zero cycles taps the edge itself
  assign latch_now  = !req_reg.write &&
                      ((cfg.read_latch_delay == 2'h0) ? cas_rise
                                                      : lat_pipe_reg[cfg.read_latch_delay - 2'h1]);

  // Sequencer next-state logic
  always_comb begin
    state_next    = state_reg;
    req_next      = req_reg;
    wdata_next    = wdata_reg;
    wave_next     = wave_reg;
    pulses_next   = pulses_reg;
    latched_next  = latched_reg;
    lat_pipe_next = {lat_pipe_reg[`DCW_TDL_W-1:0], cas_rise};
    lat_dly_next  = lat_dly_reg;
    wait_next     = wait_reg;
    hold_next     = hold_reg;
    half_next     = (state_reg == dcw_pkg::ST_SHIFT) ? !half_reg : 1'b0;
    mclk_next     = !mclk_reg;
    cas_next      = cas_reg;
    ras_next      = ras_reg;
    bank_next     = bank_reg;
    addr_next     = addr_reg;
    mwd_next      = mwd_reg;
    oe_next       = oe_reg;
    rv_next       = 1'b0;
    rd_next       = rd_reg;
    done_next     = 1'b0;
    beat_next     = beat_reg;
    if (latch_now) begin
      rv_next      = 1'b1;
      rd_next      = mem_rdata;
      latched_next = latched_reg + 4'h1;
    end
    case (state_reg)
      dcw_pkg::ST_IDLE: begin
        if (req_valid) begin
          req_next   = req;
          if ((req.beats == 4'h0) || (req.beats > `DCW_BEATS_MAX)) begin
            req_next.beats = `DCW_BEATS_MAX;
          end
          wdata_next = req_wdata;
          bank_next  = bank_select;
          addr_next  = req.addr;
          state_next = dcw_pkg::ST_ROW;
        end
      end
      dcw_pkg::ST_ROW: begin
        // Row address on pins one clock before row strobe falls
        addr_next[`DCW_MUX_HI:`DCW_MUX_LO] = row_mux;
        addr_next[`DCW_ADDR_W-1:`DCW_MUX_HI+1] = req_reg.addr[`DCW_ADDR_W-1:`DCW_MUX_HI+1];
        addr_next[`DCW_MUX_LO-1:0] = req_reg.addr[`DCW_MUX_LO-1:0];
        wave_next   = cfg.column_waveform;
        pulses_next = 4'h0;
        latched_next = 4'h0;
        beat_next   = 4'h0;
        cas_next    = 1'b1;
        state_next  = dcw_pkg::ST_SHIFT;
        ras_next    = 1'b0;
        oe_next     = !req_reg.write;
        mwd_next    = wdata_reg;
      end
      dcw_pkg::ST_SHIFT: begin
        // Column address comes in while leading ones hold strobe high
        addr_next[`DCW_MUX_HI:`DCW_MUX_LO] = col_mux;
        if (shift_en) begin
          cas_next  = wave_reg[0];
          wave_next = {1'b1, wave_reg[`DCW_WAVE_W-1:1]};
          if (cas_rise) begin
            pulses_next = pulses_reg + 4'h1;
            beat_next   = beat_reg + 4'h1;
            mwd_next    = wdata_reg;
          end
          if (last_pulse) begin
            cas_next   = 1'b1;
            state_next = dcw_pkg::ST_HOLD;
            hold_next  = req_reg.write ? 2'h0 : (cfg.read_latch_delay + 2'h2);
          end
        end
      end
      dcw_pkg::ST_HOLD: begin
        // Writes release at next memory edge; reads wait out latch plus two
        if (((req_reg.write && hold_reg == 2'h0) || (latched_reg == req_reg.beats &&
             !req_reg.write && lat_dly_reg + 4'h1 >= {2'h0, `DCW_RD_RELEASE})) && mclk_reg) begin
          ras_next   = 1'b1;
          wait_next  = cfg.precharge_wait;
          state_next = dcw_pkg::ST_PRE;
          done_next  = 1'b1;
        end else if (hold_reg != 2'h0) begin
          hold_next = hold_reg - 2'h1;
        end
        if (!req_reg.write && latched_reg == req_reg.beats && lat_dly_reg != 4'hF) begin
          lat_dly_next = lat_dly_reg + 4'h1;
        end
      end
      dcw_pkg::ST_PRE: begin
        lat_dly_next = 4'h0;
        oe_next      = 1'b1;
        if (wait_reg == 4'h0) begin
          state_next = dcw_pkg::ST_IDLE;
        end else begin
          wait_next = wait_reg - 4'h1;
        end
      end
      default: begin
        state_next = dcw_pkg::ST_IDLE;
      end
    endcase
  end

  // Register everything on the controller clock
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg    <= dcw_pkg::ST_IDLE;
      req_reg      <= '0;
      wdata_reg    <= '0;
      wave_reg     <= {`DCW_WAVE_W{1'b1}};
      pulses_reg   <= '0;
      latched_reg  <= '0;
      lat_pipe_reg <= '0;
      lat_dly_reg  <= '0;
      wait_reg     <= '0;
      hold_reg     <= '0;
      half_reg     <= 1'b0;
      mclk_reg     <= 1'b0;
      cas_reg      <= 1'b1;
      ras_reg      <= 1'b1;
      bank_reg     <= '0;
      addr_reg     <= '0;
      mwd_reg      <= '0;
      oe_reg       <= 1'b1;
      rv_reg       <= 1'b0;
      rd_reg       <= '0;
      done_reg     <= 1'b0;
      beat_reg     <= '0;
    end else begin
      state_reg    <= state_next;
      req_reg      <= req_next;
      wdata_reg    <= wdata_next;
      wave_reg     <= wave_next;
      pulses_reg   <= pulses_next;
      latched_reg  <= latched_next;
      lat_pipe_reg <= lat_pipe_next;
      lat_dly_reg  <= lat_dly_next;
      wait_reg     <= wait_next;
      hold_reg     <= hold_next;
      half_reg     <= half_next;
      mclk_reg     <= mclk_next;
      cas_reg      <= cas_next;
      ras_reg      <= ras_next;
      bank_reg     <= bank_next;
      addr_reg     <= addr_next;
      mwd_reg      <= mwd_next;
      oe_reg       <= oe_next;
      rv_reg       <= rv_next;
      rd_reg       <= rd_next;
      done_reg     <= done_next;
      beat_reg     <= beat_next;
    end
  end

  // Output flops; per-bank row strobes decoded ahead of the register
  logic [3:0] ras_bank_reg;
  logic       we_reg;
  logic       oen_reg;
  logic       ready_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ras_bank_reg <= 4'hF;
      we_reg       <= 1'b1;
      oen_reg      <= 1'b1;
      ready_reg    <= 1'b0;
    end else begin
      ras_bank_reg <= ras_next ? 4'hF : ~(4'h1 << bank_next);
      we_reg       <= ras_next | ~req_next.write;
      oen_reg      <= ras_next | req_next.write;
      ready_reg    <= (state_next == dcw_pkg::ST_IDLE);
    end
  end

  assign row_strobe_n    = ras_bank_reg;
  assign column_strobe_n = cas_reg;
  assign write_strobe_n  = we_reg;
  assign output_enable_n = oen_reg;
  assign mem_addr        = addr_reg;
  assign mem_wdata       = mwd_reg;
  assign mem_data_oe_n   = oe_reg;
  assign rdata_valid     = rv_reg;
  assign rdata           = rd_reg;
  assign done            = done_reg;
  assign req_ready       = ready_reg;
  assign mem_clk_phase   = mclk_reg;

  // Checks
  chk_ras_after_row: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == dcw_pkg::ST_ROW) |=> (ras_reg == 1'b0))
    else $error("row strobe not asserted one clock after row address");
  chk_pulse_count: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == dcw_pkg::ST_SHIFT && state_next == dcw_pkg::ST_HOLD) |->
    (pulses_next == req_reg.beats))
    else $error("strobe pulses differ from word count");
  chk_cas_follows: assert property (@(posedge ref_clk) disable iff (reset)
    shift_en && state_next == dcw_pkg::ST_SHIFT |=> (cas_reg == $past(wave_reg[0])))
    else $error("column strobe does not follow waveform bit");
  chk_half_rate: assert property (@(posedge ref_clk) disable iff (reset)
    (cfg.column_shift_half_rate && shift_en) |=> !shift_en)
    else $error("half-rate shift advanced on consecutive clocks");
  chk_we_with_ras: assert property (@(posedge ref_clk) disable iff (reset)
    !write_strobe_n |-> (row_strobe_n != 4'hF))
    else $error("write strobe active without row strobe");
  chk_ras_on_edge: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(ras_reg) |-> !mclk_reg)
    else $error("row strobe released off the memory clock edge");
  chk_precharge: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(ras_reg) |=> ras_reg[*2])
    else $error("row strobe reasserted during precharge");
  chk_one_bank: assert property (@(posedge ref_clk) disable iff (reset)
    $onehot0(~row_strobe_n))
    else $error("more than one bank row strobe active");
  chk_row_mux: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == dcw_pkg::ST_ROW) |=>
    (mem_addr[`DCW_MUX_LO+8:`DCW_MUX_LO] == req_reg.addr[18:10]))
    else $error("row address bits missing on muxed pins");

endmodule : dcw_dram_ctrl

// File: hw/dcw_pkg.sv
// Types shared by the dynamic memory column-strobe controller
`include "dcw_defines.svh"
package dcw_pkg;
  typedef struct packed {
    logic [1:0]                 row_bits_select;
    logic                       column_shift_half_rate;
    logic [`DCW_TDL_W-1:0]      read_latch_delay;
    logic [`DCW_TRP_W-1:0]      precharge_wait;
    logic [`DCW_WAVE_W-1:0]     column_waveform;
  } dcw_cfg_s;
  typedef struct packed {
    logic                       write;
    logic [`DCW_BEAT_W-1:0]     beats;
    logic [`DCW_ADDR_W-1:0]     addr;
  } dcw_req_s;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ROW   = 5'h02,
    ST_SHIFT = 5'h04,
    ST_HOLD  = 5'h08,
    ST_PRE   = 5'h10
  } dcw_state_e;
endpackage : dcw_pkg

// File: test/dcw_dram_model.sv
// Behavioural model of the asynchronous dynamic memory banks
`timescale 1ns/1ps
module dcw_dram_model (
  input  wire logic [25:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        mem_data_oe_n,
  input  wire logic [3:0]  row_strobe_n,
  input  wire logic        column_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  output logic [31:0]      mem_rdata,
  output int               wr_count,
  output logic [31:0]      last_wr
);
  wire         ras_all = &row_strobe_n;
  logic [11:0] row_q;
  // Row address taken as any bank's row strobe falls
  always @(negedge ras_all) begin
    row_q = mem_addr[21:10];
  end
  // Each column strobe fall moves one 32-bit word; data tags row and column
  always @(negedge column_strobe_n) begin
    if (!output_enable_n) begin
      mem_rdata = {8'h5A, row_q, mem_addr[21:10]};
    end
    if (!write_strobe_n) begin
      wr_count = wr_count + 1;
      last_wr = mem_data_oe_n ? ~mem_wdata : mem_wdata;
    end
  end
  // Released bus shows the inverse, so a late latch never sees a held copy
  always @(posedge output_enable_n) begin
    mem_rdata = ~mem_rdata;
  end
  initial begin
    mem_rdata = 32'h0;
    wr_count = 0;
    last_wr = 32'h0;
  end
endmodule : dcw_dram_model

// File: test/tb.sv
// Self-checking bench for the dynamic memory column-strobe sequencer
`timescale 1ns/1ps
module tb;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  dcw_pkg::dcw_cfg_s cfg;
  dcw_pkg::dcw_req_s req = '0;
  logic [1:0]        bank_select = 2'h0;
  logic              req_valid = 1'b0;
  logic [31:0]       req_wdata = 32'h0;
  logic [31:0]       mem_rdata, rdata, mem_wdata, last_wr;
  logic [25:0]       mem_addr, prev_addr, op_a;
  logic [3:0]        row_strobe_n;
  logic [1:0]        op_b;
  logic              req_ready, rdata_valid, done, mem_data_oe_n, column_strobe_n;
  logic              write_strobe_n, output_enable_n, op_w;
  logic              prev_cas = 1'b1, prev_ras = 1'b1, first_fall = 1'b0;
  logic [31:0]       rq[$];
  int                miscompares = 0, tests_run = 0, cyc = 0, last_rise = 0, lo_start = 0;
  int                lo_w = 0, lat = 0, ras_rise = 0, pre_gap = 0, take_cyc = 0, wr_count;

  dcw_dram_ctrl dut_u (.ref_clk, .reset, .cfg, .bank_select, .req_valid, .req, .req_wdata,
    .mem_rdata, .req_ready, .rdata_valid, .rdata, .done, .mem_addr, .mem_wdata,
    .mem_data_oe_n, .row_strobe_n, .column_strobe_n, .write_strobe_n, .output_enable_n,
    .mem_clk_phase());
  dcw_dram_model model_u (.mem_addr, .mem_wdata, .mem_data_oe_n, .row_strobe_n,
    .column_strobe_n, .write_strobe_n, .output_enable_n, .mem_rdata, .wr_count, .last_wr);

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task final_report;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Waveform: four idle ones, then eight beats of two low and four high bits
  function automatic logic [95:0] wave();
    logic [95:0] w;
    w = {96{1'b1}};
    for (int k = 0; k < 8; k++) begin
      w[4+6*k] = 1'b0;
      w[5+6*k] = 1'b0;
    end
    return w;
  endfunction : wave

  // Expected word: marker, row pins, column pins for this row width and beat
  function automatic logic [31:0] exp_rd(input logic [25:0] a, input int s, input int k);
    logic [11:0] c;
    c = '0;
    c[7:0] = a[9:2] + k[7:0];
    c[8] = a[19+s];
    c[9] = (s > 0) ? a[20+s] : 1'b0;
    c[10] = (s == 2) ? a[23] : 1'b0;
    return {8'h5A, a[21:10], c};
  endfunction : exp_rd

  // Column pins left undefined by the row width are masked off
  function automatic logic [31:0] msk(input int s);
    return {20'hFFFFF, 1'b0, s == 2, s > 0, 9'h1FF};
  endfunction : msk

  // One access; held until taken, then waits for the release pulse
  task automatic do_op(input logic w, input logic [3:0] n, input logic [25:0] a,
                       input logic [1:0] b);
    int k;
    rq.delete();
    lo_w = -1;
    op_w = w;
    op_a = a;
    op_b = b;
    k = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= {w, n, a};
    bank_select <= b;
    req_wdata <= {6'h00, a};
    do begin
      @(negedge ref_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    @(posedge ref_clk);
    take_cyc = cyc;
    req_valid <= 1'b0;
    while (done !== 1'b1 && k < 500) begin
      @(negedge ref_clk);
      k++;
    end
    chk(k < 500, "access hung");
    repeat (2) @(negedge ref_clk);
  endtask : do_op

  // Edge bookkeeping at the falling clock, where outputs have settled
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    if (!reset) begin
      chk((write_strobe_n & output_enable_n) === (&row_strobe_n), "enable vs row strobe");
      if (prev_cas && !column_strobe_n) begin
        if (first_fall) chk(mem_addr === prev_addr, "column setup");
        first_fall = 1'b0;
        lo_start = cyc;
      end
      if (!prev_cas && column_strobe_n) begin
        if (lo_w < 0) lo_w = cyc - lo_start;
        last_rise = cyc;
      end
      // After the rise bookkeeping, so a zero-delay latch measures zero
      if (rdata_valid === 1'b1) begin
        rq.push_back(rdata);
        lat = cyc - last_rise;
      end
      if (prev_ras && !(&row_strobe_n)) begin
        chk(prev_addr === op_a && cyc - take_cyc == 2 && row_strobe_n === ~(4'h1 << op_b),
            "row phase");
        pre_gap = cyc - ras_rise;
        first_fall = 1'b1;
      end
      if (!prev_ras && (&row_strobe_n)) begin
        ras_rise = cyc;
        chk(op_w ? ((cyc - last_rise) inside {[1:2]})
                 : ((cyc - last_rise - cfg.read_latch_delay) inside {[2:3]}),
            "row release");
      end
    end
    prev_cas = column_strobe_n;
    prev_ras = &row_strobe_n;
    prev_addr = mem_addr;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end

  // Main sequence
  initial begin
    int lat0, g0, k0;
    int nb[2];
    nb = '{8, 3};
    lat0 = 0;
    g0 = 0;
    cfg = {2'h0, 1'b0, 2'h0, 4'h8, wave()};
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // Row width sweep, one bank each
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      cfg.row_bits_select <= s[1:0];
      do_op(1'b0, 4'h1, 26'h3A56E60, s[1:0]);
      chk(rq.size() == 1 && (rq[0] & msk(s)) === exp_rd(26'h3A56E60, s, 0), "mux");
    end
    // Read latch delay sweep
    for (int t = 0; t < 4; t++) begin
      @(posedge ref_clk);
      cfg.read_latch_delay <= t[1:0];
      do_op(1'b0, 4'h1, 26'h0154320, 2'h2);
      if (t == 0) lat0 = lat;
      chk(lat0 == 0 && lat - lat0 == t && (rq[0] & msk(3)) === exp_rd(26'h0154320, 3, 0),
          "latch");
    end
    // Bursts at full and half shift rate
    for (int h = 0; h < 2; h++) begin
      @(posedge ref_clk);
      cfg.column_shift_half_rate <= h[0];
      foreach (nb[i]) begin
        do_op(1'b0, nb[i][3:0], 26'h2C31A80, 2'h1);
        chk(rq.size() == nb[i] && lo_w == 2 + 2 * h, "burst rate");
        foreach (rq[k]) chk((rq[k] & msk(3)) === exp_rd(26'h2C31A80, 3, k), "beat");
      end
    end
    // Write bursts
    foreach (nb[i]) begin
      k0 = wr_count;
      do_op(1'b1, nb[i][3:0], 26'h1F00040, 2'h3);
      chk(wr_count - k0 == nb[i] && last_wr === 32'h01F00040 && rq.size() == 0, "write");
    end
    // Back-to-back reads at two precharge settings
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      cfg.precharge_wait <= p ? 4'hD : 4'h8;
      do_op(1'b0, 4'h1, 26'h0000040, 2'h0);
      do_op(1'b0, 4'h1, 26'h0000040, 2'h0);
      if (p == 0) g0 = pre_gap;
    end
    chk(pre_gap - g0 == 5 && g0 > 8, "precharge");
    final_report();
  end
endmodule : tb
